//--- verilog/ubc_pkg.sv
// Constants shared by the baud-rate control block and its helpers
package ubc_pkg;
  localparam logic [11:0] ADDR_BAUD_CTRL = 12'h11f;
  localparam logic [11:0] ADDR_LINK_CTRL = 12'h120;
  localparam logic [11:0] ADDR_DIV_LO = 12'h121;
  localparam logic [11:0] ADDR_DIV_HI = 12'h122;
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h123;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h124;
  localparam int BRC_OVF_BIT = 7;
  localparam int BRC_IDLE_BIT = 6;
  localparam int BRC_POL_BIT = 4;
  localparam int BRC_WIDE_BIT = 3;
  localparam int BRC_WAKE_BIT = 1;
  localparam int BRC_ABD_BIT = 0;
  localparam logic [7:0] BRC_RESET = 8'h00;
  localparam int LNK_SYNC_BIT = 0;
  localparam int LNK_TX_ON_BIT = 1;
  localparam int LNK_ONE_RX_BIT = 2;
  localparam int LNK_CONT_RX_BIT = 3;
  localparam int LNK_HS_BIT = 4;
  localparam logic [7:0] LNK_RESET = 8'h00;
  localparam int EV_WAKE = 0;
  localparam int EV_ABD_DONE = 1;
  localparam int EV_ABD_OVF = 2;
  localparam int EV_COUNT = 3;
  localparam logic [EV_COUNT-1:0] EV_RESET = 3'h0;
  localparam logic [15:0] DIV_RESET = 16'h0000;
  localparam logic [6:0] PRESC_FAST = 7'h04;
  localparam logic [6:0] PRESC_MID = 7'h10;
  localparam logic [6:0] PRESC_SLOW = 7'h40;
  localparam logic [3:0] FRAME_BITS = 4'ha;
  localparam logic [2:0] ABD_RISES = 3'h5;
  localparam int ABD_CNT_W = 20;
  localparam int ABD_SHIFT = 3;
  typedef enum logic [1:0] {ABD_IDLE, ABD_WAIT_FALL, ABD_MEASURE} ubc_abd_state_e;
endpackage : ubc_pkg

//--- verilog/ubc_rate_if.sv
// Signals shared between the control core, rate generator and auto-baud unit
`timescale 1ns/1ps
`default_nettype none
interface ubc_rate_if;
  logic [15:0] divisor;
  logic wide;
  logic high_speed;
  logic sync_mode;
  logic presc_tick;
  logic tick;
  logic rx_fall;
  logic rx_rise;
  logic abd_run;
  logic abd_done;
  logic abd_ovf;
  logic [15:0] abd_value;
  modport gen (input divisor, wide, high_speed, sync_mode, output presc_tick, tick);
  modport abd (input presc_tick, rx_fall, rx_rise, wide, abd_run,
               output abd_done, abd_ovf, abd_value);
  modport ctl (output divisor, wide, high_speed, sync_mode, rx_fall, rx_rise, abd_run,
               input presc_tick, tick, abd_done, abd_ovf, abd_value);
endinterface : ubc_rate_if
`default_nettype wire

//--- verilog/ubc_rate_gen.sv
// Prescaler plus 8- or 16-bit divisor that produces the bit-rate tick
`timescale 1ns/1ps
`default_nettype none
module ubc_rate_gen
  import ubc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  ubc_rate_if.gen rif
);
  logic [6:0] presc_q;
  logic [6:0] presc_d;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic presc_tick_q;
  logic tick_q;
  wire [6:0] presc_len;
  wire [15:0] reload;
  wire presc_end;

  // Synchronous links always run at the fastest prescale
  assign presc_len = (rif.sync_mode || (rif.wide && rif.high_speed)) ? PRESC_FAST :
                     (rif.wide || rif.high_speed) ? PRESC_MID : PRESC_SLOW;
  assign reload = rif.wide ? rif.divisor : {8'h00, rif.divisor[7:0]};
  assign presc_end = (presc_q >= presc_len - 7'h01);
  assign presc_d = presc_end ? 7'h00 : presc_q + 7'h01;
  assign cnt_d = !presc_end ? cnt_q : (cnt_q == 16'h0000) ? reload : cnt_q - 16'h0001;

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      presc_q <= 7'h00;
      cnt_q <= DIV_RESET;
      presc_tick_q <= 1'b0;
      tick_q <= 1'b0;
    end
    else
    begin
      presc_q <= presc_d;
      cnt_q <= cnt_d;
      presc_tick_q <= presc_end;
      tick_q <= presc_end && (cnt_q == 16'h0000);
    end
  end

  assign rif.presc_tick = presc_tick_q;
  assign rif.tick = tick_q;

  a_presc_spacing: assert property (@(posedge core_clk) disable iff (!rstn)
    (presc_tick_q && $stable(presc_len) && presc_len == PRESC_FAST)
      |-> ##4 (presc_tick_q || presc_len != PRESC_FAST))
    else $error("prescale tick spacing wrong for fast rate");
endmodule : ubc_rate_gen
`default_nettype wire

//--- verilog/ubc_autobaud.sv
// Auto-baud measurement over nine bit times of a calibration character
`timescale 1ns/1ps
`default_nettype none
module ubc_autobaud
  import ubc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  ubc_rate_if.abd rif
);
  ubc_abd_state_e state_q;
  logic [ABD_CNT_W-1:0] cnt_q;
  logic [2:0] rises_q;
  logic done_q;
  logic ovf_q;
  logic [15:0] value_q;
  wire overflow;
  wire last_rise;

  // Narrow generator overflows once the per-bit count leaves the low byte
  assign overflow = cnt_q[ABD_CNT_W-1] || (!rif.wide && (cnt_q[ABD_CNT_W-2:11] != 8'h00));
  assign last_rise = rif.rx_rise && (rises_q == ABD_RISES - 3'h1);

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      state_q <= ABD_IDLE;
      cnt_q <= '0;
      rises_q <= 3'h0;
      done_q <= 1'b0;
      ovf_q <= 1'b0;
      value_q <= DIV_RESET;
    end
    else
    begin
      done_q <= 1'b0;
      ovf_q <= 1'b0;
      case (state_q)
        ABD_IDLE:
          if (rif.abd_run)
            state_q <= ABD_WAIT_FALL;
        ABD_WAIT_FALL:
          if (!rif.abd_run)
            state_q <= ABD_IDLE;
          else if (rif.rx_fall)
          begin
            state_q <= ABD_MEASURE;
            cnt_q <= '0;
            rises_q <= 3'h0;
          end
        ABD_MEASURE:
          if (!rif.abd_run)
            state_q <= ABD_IDLE;
          else if (overflow)
          begin
            ovf_q <= 1'b1;
            state_q <= ABD_IDLE;
          end
          else if (last_rise)
          begin
            done_q <= 1'b1;
            value_q <= cnt_q[ABD_SHIFT+15:ABD_SHIFT];
            state_q <= ABD_IDLE;
          end
          else
          begin
            if (rif.presc_tick)
              cnt_q <= cnt_q + 20'h00001;
            if (rif.rx_rise)
              rises_q <= rises_q + 3'h1;
          end
        default:
          state_q <= ABD_IDLE;
      endcase
    end
  end

  assign rif.abd_done = done_q;
  assign rif.abd_ovf = ovf_q;
  assign rif.abd_value = value_q;

  a_abd_one_result: assert property (@(posedge core_clk) disable iff (!rstn)
    done_q |-> !ovf_q ##1 (!done_q && !ovf_q))
    else $error("auto-baud reported twice or both results");
endmodule : ubc_autobaud
`default_nettype wire

//--- verilog/ubc_baud_control.sv
// Baud-rate control, status and link-direction logic of the serial port
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module ubc_baud_control
  import ubc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic rx_pin,
  output logic tx_line,
  output logic sync_clk,
  output logic shift_strobe,
  output logic receive_active,
  output logic transmit_active,
  output logic receive_interrupt_flag,
  output logic irq
);
  function automatic logic ubc_hit(input logic [11:0] a, input logic [11:0] t);
    return a == t;
  endfunction : ubc_hit

  ubc_rate_if rif();

  logic autobaud_overflow_flag_q;
  logic receiver_idle_flag_q;
  logic line_polarity_select_q;
  logic wide_generator_select_q;
  logic wakeup_enable_q;
  logic autobaud_enable_q;
  logic sync_mode_q;
  logic transmit_enable_q;
  logic single_receive_enable_q;
  logic continuous_receive_enable_q;
  logic high_speed_select_q;
  logic [15:0] div_q;
  logic [EV_COUNT-1:0] istat_q;
  logic [EV_COUNT-1:0] istat_d;
  logic [EV_COUNT-1:0] imask_q;
  logic [7:0] rdata_q;
  logic rx_s1_q;
  logic rx_s2_q;
  logic rx_s3_q;
  logic rx_lvl_q;
  logic [3:0] bitcnt_q;
  logic wake_clr_q;
  logic tx_q;
  logic sck_q;
  logic strobe_q;
  logic rxact_q;
  logic txact_q;
  logic irq_q;

  wire wr_brc = reg_wr && ubc_hit(reg_addr, ADDR_BAUD_CTRL);
  wire wr_lnk = reg_wr && ubc_hit(reg_addr, ADDR_LINK_CTRL);
  wire wr_dlo = reg_wr && ubc_hit(reg_addr, ADDR_DIV_LO);
  wire wr_dhi = reg_wr && ubc_hit(reg_addr, ADDR_DIV_HI);
  wire wr_msk = reg_wr && ubc_hit(reg_addr, ADDR_IRQ_MASK);
  wire rd_ist = reg_rd && ubc_hit(reg_addr, ADDR_IRQ_STATUS);
  wire rd_brc = reg_rd && ubc_hit(reg_addr, ADDR_BAUD_CTRL);

  // A level change counts only once the last two stages agree
  wire rx_settled = (rx_s2_q == rx_s3_q);
  wire rx_fall = rx_settled && rx_lvl_q && !rx_s3_q;
  wire rx_rise = rx_settled && !rx_lvl_q && rx_s3_q;
  wire rx_any_enable = single_receive_enable_q || continuous_receive_enable_q;
  wire link_busy = sync_mode_q && (transmit_enable_q || rx_any_enable);
  wire wake_ev = !sync_mode_q && wakeup_enable_q && rx_fall;
  wire start_ev = !sync_mode_q && continuous_receive_enable_q && !wakeup_enable_q
                  && !autobaud_enable_q && receiver_idle_flag_q && rx_fall;
  wire frame_end = !receiver_idle_flag_q && rif.tick && (bitcnt_q == FRAME_BITS - 4'h1);
  wire [EV_COUNT-1:0] events = {rif.abd_ovf && !sync_mode_q, rif.abd_done, wake_ev};
  wire [7:0] brc_view = {autobaud_overflow_flag_q, receiver_idle_flag_q, 1'b0,
                         line_polarity_select_q, wide_generator_select_q, 1'b0,
                         wakeup_enable_q, autobaud_enable_q};
  wire [7:0] lnk_view = {3'h0, high_speed_select_q, continuous_receive_enable_q,
                         single_receive_enable_q, transmit_enable_q, sync_mode_q};
  wire [7:0] rd_val = ubc_hit(reg_addr, ADDR_BAUD_CTRL) ? brc_view :
                      ubc_hit(reg_addr, ADDR_LINK_CTRL) ? lnk_view :
                      ubc_hit(reg_addr, ADDR_DIV_LO) ? div_q[7:0] :
                      ubc_hit(reg_addr, ADDR_DIV_HI) ? div_q[15:8] :
                      ubc_hit(reg_addr, ADDR_IRQ_STATUS) ? {5'h00, istat_q} :
                      ubc_hit(reg_addr, ADDR_IRQ_MASK) ? {5'h00, imask_q} : 8'h00;
  // New events win over the clear that a status read performs
  assign istat_d = (rd_ist ? EV_RESET : istat_q) | events;
  wire sck_next = ~sck_q;

  assign rif.divisor = div_q;
  assign rif.wide = wide_generator_select_q;
  assign rif.high_speed = high_speed_select_q;
  assign rif.sync_mode = sync_mode_q;
  assign rif.rx_fall = rx_fall;
  assign rif.rx_rise = rx_rise;
  assign rif.abd_run = autobaud_enable_q && !sync_mode_q;

  ubc_rate_gen u_gen (
    .core_clk (core_clk),
    .rstn (rstn),
    .rif (rif.gen)
  );

  ubc_autobaud u_abd (
    .core_clk (core_clk),
    .rstn (rstn),
    .rif (rif.abd)
  );

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
      rx_s3_q <= 1'b1;
      rx_lvl_q <= 1'b1;
    end
    else
    begin
      rx_s1_q <= rx_pin;
      rx_s2_q <= rx_s1_q;
      rx_s3_q <= rx_s2_q;
      if (rx_settled)
        rx_lvl_q <= rx_s3_q;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      line_polarity_select_q <= BRC_RESET[BRC_POL_BIT];
      wide_generator_select_q <= BRC_RESET[BRC_WIDE_BIT];
      wakeup_enable_q <= BRC_RESET[BRC_WAKE_BIT];
      autobaud_enable_q <= BRC_RESET[BRC_ABD_BIT];
      autobaud_overflow_flag_q <= BRC_RESET[BRC_OVF_BIT];
      wake_clr_q <= 1'b0;
    end
    else
    begin
      wake_clr_q <= wake_ev;
      if (wr_brc)
      begin
        line_polarity_select_q <= reg_wdata[BRC_POL_BIT];
        wide_generator_select_q <= reg_wdata[BRC_WIDE_BIT];
      end
      if (wr_brc)
        wakeup_enable_q <= reg_wdata[BRC_WAKE_BIT];
      else if (wake_clr_q)
        wakeup_enable_q <= 1'b0;
      if (wr_brc)
        autobaud_enable_q <= reg_wdata[BRC_ABD_BIT];
      else if (rif.abd_done || rif.abd_ovf)
        autobaud_enable_q <= 1'b0;
      if (sync_mode_q)
        autobaud_overflow_flag_q <= 1'b0;
      else if (rif.abd_ovf)
        autobaud_overflow_flag_q <= 1'b1;
      else if (wr_brc && reg_wdata[BRC_ABD_BIT])
        autobaud_overflow_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      sync_mode_q <= LNK_RESET[LNK_SYNC_BIT];
      transmit_enable_q <= LNK_RESET[LNK_TX_ON_BIT];
      single_receive_enable_q <= LNK_RESET[LNK_ONE_RX_BIT];
      continuous_receive_enable_q <= LNK_RESET[LNK_CONT_RX_BIT];
      high_speed_select_q <= LNK_RESET[LNK_HS_BIT];
      div_q <= DIV_RESET;
      imask_q <= EV_RESET;
      istat_q <= EV_RESET;
    end
    else
    begin
      if (wr_lnk)
      begin
        sync_mode_q <= reg_wdata[LNK_SYNC_BIT];
        transmit_enable_q <= reg_wdata[LNK_TX_ON_BIT];
        single_receive_enable_q <= reg_wdata[LNK_ONE_RX_BIT];
        continuous_receive_enable_q <= reg_wdata[LNK_CONT_RX_BIT];
        high_speed_select_q <= reg_wdata[LNK_HS_BIT];
      end
      // A finished measurement overrides a divisor write in the same cycle
      if (rif.abd_done)
        div_q <= rif.abd_value;
      else if (wr_dlo)
        div_q[7:0] <= reg_wdata;
      else if (wr_dhi)
        div_q[15:8] <= reg_wdata;
      if (wr_msk)
        imask_q <= reg_wdata[EV_COUNT-1:0];
      istat_q <= istat_d;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      receiver_idle_flag_q <= 1'b1;
      bitcnt_q <= 4'h0;
    end
    else if (sync_mode_q || !continuous_receive_enable_q || frame_end)
    begin
      receiver_idle_flag_q <= 1'b1;
      bitcnt_q <= 4'h0;
    end
    else if (start_ev)
    begin
      receiver_idle_flag_q <= 1'b0;
      bitcnt_q <= 4'h0;
    end
    else if (!receiver_idle_flag_q && rif.tick)
      bitcnt_q <= bitcnt_q + 4'h1;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      tx_q <= 1'b1;
      sck_q <= 1'b0;
      strobe_q <= 1'b0;
      rxact_q <= 1'b0;
      txact_q <= 1'b0;
      irq_q <= 1'b0;
      rdata_q <= 8'h00;
    end
    else
    begin
      tx_q <= sync_mode_q ? 1'b0 : !line_polarity_select_q;
      sck_q <= !link_busy ? 1'b0 : rif.tick ? sck_next : sck_q;
      strobe_q <= link_busy && rif.tick && (sck_next == line_polarity_select_q);
      rxact_q <= sync_mode_q ? rx_any_enable : continuous_receive_enable_q;
      txact_q <= transmit_enable_q && !(sync_mode_q && rx_any_enable);
      irq_q <= |(istat_d & imask_q);
      rdata_q <= reg_rd ? rd_val : 8'h00;
    end
  end

  assign reg_rdata = rdata_q;
  assign tx_line = tx_q;
  assign sync_clk = sck_q;
  assign shift_strobe = strobe_q;
  assign receive_active = rxact_q;
  assign transmit_active = txact_q;
  assign receive_interrupt_flag = istat_q[EV_WAKE];
  assign irq = irq_q;

  a_rx_over_tx: assert property (@(posedge core_clk) disable iff (!rstn)
    (sync_mode_q && rx_any_enable) |=> !txact_q)
    else $error("transmit active while synchronous receive enabled");
  a_ovf_flag_set: assert property (@(posedge core_clk) disable iff (!rstn)
    (rif.abd_ovf && !sync_mode_q) |=> autobaud_overflow_flag_q ##1 !autobaud_enable_q)
    else $error("overflow did not raise flag or stop auto-baud");
  a_idle_drops: assert property (@(posedge core_clk) disable iff (!rstn)
    start_ev |=> !receiver_idle_flag_q && !brc_view[BRC_IDLE_BIT])
    else $error("idle flag stayed high after start bit");
  a_tx_idle_pol: assert property (@(posedge core_clk) disable iff (!rstn)
    (!sync_mode_q && $stable(line_polarity_select_q))
      |=> tx_q == !$past(line_polarity_select_q))
    else $error("transmit idle level does not follow polarity");
  a_strobe_edge: assert property (@(posedge core_clk) disable iff (!rstn)
    strobe_q |-> sck_q == $past(line_polarity_select_q) && $changed(sck_q))
    else $error("data strobe on wrong clock edge");
  a_wake_flag: assert property (@(posedge core_clk) disable iff (!rstn)
    (wake_ev && !wr_brc) |=> istat_q[EV_WAKE] ##1 (!wakeup_enable_q || $past(wr_brc)))
    else $error("wake edge did not set flag and clear enable");
  a_abd_clears: assert property (@(posedge core_clk) disable iff (!rstn)
    (rif.abd_done && !wr_brc) |=> !autobaud_enable_q && div_q == $past(rif.abd_value))
    else $error("auto-baud completion not applied");
  a_reserved_zero: assert property (@(posedge core_clk) disable iff (!rstn)
    rd_brc |=> reg_rdata[5] == 1'b0 && reg_rdata[2] == 1'b0)
    else $error("reserved baud control bits read nonzero");
endmodule : ubc_baud_control
`default_nettype wire

//--- testbench/ubc_remote_dev.sv
// Behavioural remote serial device that drives the receive line
`timescale 1ns/1ps
`default_nettype none
module ubc_remote_dev (
  input wire logic core_clk,
  output var logic rx_pin
);
  // Line idles high between characters, as a pulled-up serial line would
  initial rx_pin = 1'b1;

  task automatic drive_low(input int cycles);
    @(posedge core_clk);
    rx_pin <= 1'b0;
    repeat (cycles) @(posedge core_clk);
    rx_pin <= 1'b1;
  endtask : drive_low

  task automatic send_char(input logic [7:0] data, input int bit_cycles);
    logic [9:0] frame;
    frame = {1'b1, data, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge core_clk);
      rx_pin <= frame[i];
      repeat (bit_cycles - 1) @(posedge core_clk);
    end
  endtask : send_char
endmodule : ubc_remote_dev
`default_nettype wire

//--- testbench/tb.sv
// Self-checking bench for the baud-rate control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ubc_pkg::*;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] rv;
  wire logic [7:0] reg_rdata;
  wire logic rx_pin, tx_line, sync_clk, shift_strobe;
  wire logic receive_active, transmit_active, receive_interrupt_flag, irq;
  int miscompares = 0;
  int comparisons = 0;

  always #2.5 core_clk = ~core_clk;

  ubc_remote_dev rdev (.core_clk(core_clk), .rx_pin(rx_pin));
  ubc_baud_control uut (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_pin(rx_pin), .tx_line(tx_line), .sync_clk(sync_clk), .shift_strobe(shift_strobe),
    .receive_active(receive_active), .transmit_active(transmit_active),
    .receive_interrupt_flag(receive_interrupt_flag), .irq(irq));

  task automatic close_out;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  task automatic rd_chk(input string what, input logic [11:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(what, exp, d);
  endtask : rd_chk

  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : settle

  // Polls the flag output; a bound that runs out ends the run
  task automatic wait_flag(input logic exp, input int limit);
    int i;
    for (i = 0; i < limit && receive_interrupt_flag !== exp; i++) @(posedge core_clk);
    #1;
    if (receive_interrupt_flag !== exp)
    begin
      miscompares++;
      $display("FAIL receive_interrupt_flag expected %b seen %b", exp, receive_interrupt_flag);
      close_out();
    end
  endtask : wait_flag

  task automatic t_reset;
    rd_chk("baud_rate_control", ADDR_BAUD_CTRL, 8'h40);
    rd_chk("link_ctrl", ADDR_LINK_CTRL, 8'h00);
    rd_chk("irq_status", ADDR_IRQ_STATUS, 8'h00);
    chk("tx_line", 8'h01, {7'h00, tx_line});
    chk("irq", 8'h00, {7'h00, irq});
  endtask : t_reset

  task automatic t_bits;
    wr(ADDR_BAUD_CTRL, 8'h3c);
    rd_chk("baud_rate_control", ADDR_BAUD_CTRL, 8'h58);
    chk("tx_line inverted", 8'h00, {7'h00, tx_line});
    wr(ADDR_BAUD_CTRL, 8'hc0);
    rd_chk("read only bits", ADDR_BAUD_CTRL, 8'h40);
    chk("tx_line idle", 8'h01, {7'h00, tx_line});
    wr(12'h125, 8'hff);
    rd_chk("unmapped", 12'h125, 8'h00);
    rd_chk("link_ctrl", ADDR_LINK_CTRL, 8'h00);
  endtask : t_bits

  task automatic t_wake;
    wr(ADDR_IRQ_MASK, 8'h01);
    wr(ADDR_BAUD_CTRL, 8'h02);
    rdev.drive_low(20);
    wait_flag(1'b1, 30);
    chk("irq", 8'h01, {7'h00, irq});
    rd_chk("wake cleared", ADDR_BAUD_CTRL, 8'h40);
    rd_chk("irq_status", ADDR_IRQ_STATUS, 8'h01);
    rd_chk("irq_status cleared", ADDR_IRQ_STATUS, 8'h00);
    settle(2);
    chk("irq low", 8'h00, {7'h00, irq});
    wr(ADDR_IRQ_MASK, 8'h00);
    wr(ADDR_BAUD_CTRL, 8'h02);
    rdev.drive_low(20);
    wait_flag(1'b1, 30);
    chk("irq masked", 8'h00, {7'h00, irq});
    rd_chk("irq_status", ADDR_IRQ_STATUS, 8'h01);
    // Sync mode ignores the wake-up request
    wr(ADDR_LINK_CTRL, 8'h01);
    wr(ADDR_BAUD_CTRL, 8'h02);
    rdev.drive_low(20);
    settle(20);
    chk("sync wake", 8'h00, {7'h00, receive_interrupt_flag});
    wr(ADDR_BAUD_CTRL, 8'h00);
    wr(ADDR_LINK_CTRL, 8'h00);
  endtask : t_wake

  task automatic t_idle;
    wr(ADDR_LINK_CTRL, 8'h18);
    wr(ADDR_BAUD_CTRL, 8'h08);
    rdev.drive_low(8);
    rd_chk("receiving", ADDR_BAUD_CTRL, 8'h08);
    settle(60);
    rd_chk("idle again", ADDR_BAUD_CTRL, 8'h48);
    wr(ADDR_LINK_CTRL, 8'h00);
    wr(ADDR_BAUD_CTRL, 8'h00);
  endtask : t_idle

  task automatic t_abd;
    wr(ADDR_IRQ_MASK, 8'h06);
    wr(ADDR_LINK_CTRL, 8'h10);
    wr(ADDR_BAUD_CTRL, 8'h09);
    // Nine bit times of 64 cycles at prescale 4 give 144 ticks, divided by 8
    rdev.send_char(8'h55, 64);
    settle(4);
    chk("irq done", 8'h01, {7'h00, irq});
    rd_chk("autobaud cleared", ADDR_BAUD_CTRL, 8'h48);
    rd_chk("irq_status done", ADDR_IRQ_STATUS, 8'h02);
    rd(ADDR_DIV_LO, rv);
    chk("divisor in range", 8'h01, {7'h00, rv == 8'h12 || rv == 8'h11});
    // Narrow generator at prescale 16 overflows after 2048 ticks
    wr(ADDR_BAUD_CTRL, 8'h01);
    rdev.drive_low(34000);
    settle(8);
    rd_chk("overflow", ADDR_BAUD_CTRL, 8'hc0);
    rd_chk("irq_status ovf", ADDR_IRQ_STATUS, 8'h04);
    wr(ADDR_LINK_CTRL, 8'h01);
    rd(ADDR_BAUD_CTRL, rv);
    chk("overflow in sync", 8'h00, rv & 8'h80);
    wr(ADDR_LINK_CTRL, 8'h00);
  endtask : t_abd

  task automatic t_sync;
    int n;
    wr(ADDR_LINK_CTRL, 8'h03);
    for (int p = 0; p < 2; p++)
    begin
      wr(ADDR_BAUD_CTRL, p[0] ? 8'h10 : 8'h00);
      n = 0;
      repeat (100)
      begin
        @(posedge core_clk);
        #1;
        if (shift_strobe === 1'b1)
        begin
          n++;
          chk("strobe edge", {7'h00, p[0]}, {7'h00, sync_clk});
        end
      end
      chk("strobes seen", 8'h01, {7'h00, n > 0});
    end
    chk("tx_line sync", 8'h00, {7'h00, tx_line});
    chk("transmit_active", 8'h01, {7'h00, transmit_active});
    wr(ADDR_LINK_CTRL, 8'h07);
    settle(2);
    chk("single rx wins", 8'h02, {6'h00, receive_active, transmit_active});
    wr(ADDR_LINK_CTRL, 8'h0b);
    settle(2);
    chk("cont rx wins", 8'h02, {6'h00, receive_active, transmit_active});
    wr(ADDR_LINK_CTRL, 8'h0a);
    settle(2);
    chk("async both", 8'h03, {6'h00, receive_active, transmit_active});
    wr(ADDR_LINK_CTRL, 8'h00);
    wr(ADDR_BAUD_CTRL, 8'h00);
  endtask : t_sync

  initial
  begin
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    t_reset();
    t_bits();
    t_wake();
    t_idle();
    t_sync();
    t_abd();
    close_out();
  end
endmodule : tb
`default_nettype wire
